// ---- logic/tcmux_ctrl.sv ----
/*
  Control and status logic of the two-channel bus multiplexer: the
  two-wire slave on the link clock, and the registers, connection,
  timeout and fault logic on the system clock.
  Assumes link_clk oversamples the two-wire lines, free running, and
  analog front ends give sensed levels of all pins.
*/
`timescale 1ns/1ps
module tcmux_ctrl #(
  parameter int TMO_LONG = tcmux_pkg::TMO_LONG_CYC,
  parameter int TMO_MID = tcmux_pkg::TMO_MID_CYC,
  parameter int TMO_SHORT = tcmux_pkg::TMO_SHORT_CYC
) (
  // Clocks and reset
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic link_clk,
  // Upstream two-wire bus
  input wire logic upstream_clock_line,
  input wire logic upstream_data_line_in,
  output logic upstream_data_line_out,
  output logic upstream_data_line_oe,
  // Downstream sensed levels
  input wire logic downstream_fault_in_first,
  input wire logic downstream_fault_in_second,
  input wire logic downstream_data_first,
  input wire logic downstream_clock_first,
  input wire logic downstream_data_second,
  input wire logic downstream_clock_second,
  // Enable and address straps
  input wire logic enable_in,
  input wire logic [1:0] tristate_address_pin_low,
  input wire logic [1:0] tristate_address_pin_mid,
  input wire logic [1:0] tristate_address_pin_high,
  // Open-drain status pins
  output logic fault_line_out,
  output logic fault_line_oe,
  output logic ready_line_out,
  output logic ready_line_oe,
  // To switch and accelerator stages
  output logic [1:0] channel_join,
  output logic upstream_accel_en,
  output logic downstream_accel_en,
  output logic stuck_disconnect
);
  import tcmux_pkg::*;

  // Link-side registers seen by the system side
  logic wr_tgl;
  logic [1:0] wr_addr;
  logic [7:0] wr_data;

  // System-side state
  logic [9:0] s_syn;
  logic tgl_d;
  logic wr_pulse;
  logic reg_rst;
  logic hold;
  logic [7:0] accel;
  logic [7:0] cfg;
  logic [1:0] bus_hi;
  logic up_stuck;
  logic [1:0] next_join;
  logic [1:0] refused;
  logic fail_seen;
  logic tmo_latched;
  logic [TMO_CNT_W-1:0] tmo_cnt;
  logic [TMO_CNT_W-1:0] tmo_lim;
  logic tmo_hit;
  logic stat_clear;
  logic sw_write;
  logic [7:0] status;
  logic [31:0] rd_img;

  tcmux_sync #(.WIDTH(10)) u_sys_sync (
    .clk(sys_clk),
    .async_in({downstream_fault_in_first, downstream_fault_in_second,
               downstream_data_first, downstream_clock_first,
               downstream_data_second, downstream_clock_second,
               upstream_clock_line, upstream_data_line_in,
               enable_in, wr_tgl}),
    .sync_out(s_syn)
  );

  assign bus_hi[0] = s_syn[7] & s_syn[6];
  assign bus_hi[1] = s_syn[5] & s_syn[4];
  assign up_stuck = ~s_syn[3] | ~s_syn[2];
  assign reg_rst = reset | ~s_syn[1]; // RULE4
  assign wr_pulse = s_syn[0] ^ tgl_d;
  assign stat_clear = wr_pulse && wr_addr == REG_STATUS; // RULE14
  assign sw_write = wr_pulse && wr_addr == REG_SWITCH;

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      tgl_d <= 1'b0;
    else
      tgl_d <= s_syn[0];
  end

  // Link logic is held idle during reset and while disabled
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      hold <= 1'b1;
    else
      hold <= ~s_syn[1]; // RULE4 RULE5
  end

  always_ff @(posedge sys_clk)
  begin
    if (reg_rst)
    begin
      accel <= ACCEL_RESET;
      cfg <= CONNCFG_RESET;
    end
    else if (wr_pulse && wr_addr == REG_ACCEL)
      accel <= wr_data & ACCEL_WMASK; // RULE15 RULE16
    else if (wr_pulse && wr_addr == REG_CONNCFG)
      cfg <= wr_data & CONNCFG_WMASK;
  end

  assign upstream_accel_en = accel[AC_UP]; // RULE15
  assign downstream_accel_en = accel[AC_DOWN]; // RULE16

  // A channel already joined stays joined while its switch bit is written set; its sensed level is moot
  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      next_join[i] = wr_data[SW_CH1-i]
                   & (cfg[CF_CONNREQ] | bus_hi[i] | channel_join[i]); // RULE17
      refused[i] = wr_data[SW_CH1-i] & ~next_join[i]; // RULE3
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reg_rst)
      channel_join <= 2'h0;
    else if (tmo_hit)
      channel_join <= 2'h0;
    else if (sw_write)
      channel_join <= next_join;
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge sys_clk)
  begin
    if (reg_rst)
      fail_seen <= 1'b0;
    else if (sw_write && |refused)
      fail_seen <= 1'b1; // RULE11
    else if (stat_clear)
      fail_seen <= 1'b0; // RULE14
  end

  always_comb
  begin
    case (tcmux_tmo_t'(cfg[1:0])) // RULE18
      TMO_30MS: tmo_lim = TMO_LONG[TMO_CNT_W-1:0];
      TMO_15MS: tmo_lim = TMO_MID[TMO_CNT_W-1:0];
      TMO_7P5MS: tmo_lim = TMO_SHORT[TMO_CNT_W-1:0];
      default: tmo_lim = '0;
    endcase
  end

  assign tmo_hit = cfg[1:0] != TMO_OFF && up_stuck && tmo_cnt == tmo_lim;

  always_ff @(posedge sys_clk)
  begin
    if (reg_rst || !up_stuck || cfg[1:0] == TMO_OFF)
      tmo_cnt <= '0;
    else if (tmo_cnt != tmo_lim)
      tmo_cnt <= tmo_cnt + 1'b1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (reg_rst)
      stuck_disconnect <= 1'b0;
    else
      stuck_disconnect <= tmo_hit; // RULE13
  end

  always_ff @(posedge sys_clk)
  begin
    if (reg_rst)
      tmo_latched <= 1'b0;
    else if (tmo_hit)
      tmo_latched <= 1'b1; // RULE12
    else if (stat_clear)
      tmo_latched <= 1'b0; // RULE14
  end

  // Fault inputs still reach the pin while disabled
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      fault_line_oe <= 1'b0;
    else
      fault_line_oe <= ~s_syn[9] | ~s_syn[8] // RULE1
                     | tmo_latched | fail_seen; // RULE2 RULE3 RULE19
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      ready_line_oe <= 1'b1;
    else
      ready_line_oe <= ~|channel_join; // RULE6
  end

  assign fault_line_out = 1'b0;
  assign ready_line_out = 1'b0;

  always_comb
  begin
    status = 8'h00;
    status[ST_JOINED] = |channel_join; // RULE9
    status[ST_FAULT1] = s_syn[9]; // RULE10
    status[ST_FAULT2] = s_syn[8]; // RULE10
    status[ST_FAIL_N] = ~fail_seen; // RULE11
    status[ST_TMO_LATCH] = tmo_latched; // RULE12
    status[ST_TMO_NOW] = stuck_disconnect; // RULE13
  end

  assign rd_img = {channel_join[0], channel_join[1], 2'b00,
                   bus_hi[0], bus_hi[1], 2'b00, cfg, accel, status};

  // Link side: slave engine on the sampling clock
  logic [42:0] l_syn;
  logic lhold;
  logic lfault;
  logic lmass;
  logic [31:0] limg;
  logic scl_q;
  logic sda_q;
  logic scl_d;
  logic sda_d;
  logic start_c;
  logic stop_c;
  logic rise;
  logic fall;
  logic [6:0] own_addr;
  tcmux_state_t state;
  logic [3:0] bitc;
  logic [7:0] shift;
  logic [7:0] tx;
  logic [1:0] ptr;
  logic first;
  logic rw;
  logic ara;
  logic nack;
  logic match;

  // Image words are quasi-static; a byte read mid-change may mix bits
  tcmux_sync #(.WIDTH(43)) u_link_sync (
    .clk(link_clk),
    .async_in({hold, fault_line_oe, cfg[CF_MASSWR], rd_img,
               tristate_address_pin_high, tristate_address_pin_mid,
               tristate_address_pin_low,
               upstream_clock_line, upstream_data_line_in}),
    .sync_out(l_syn)
  );

  assign lhold = l_syn[42];
  assign lfault = l_syn[41];
  assign lmass = l_syn[40];
  assign limg = l_syn[39:8];
  assign own_addr = tcmux_addr(l_syn[7:6], l_syn[5:4], l_syn[3:2]); // RULE7
  assign scl_q = l_syn[1];
  assign sda_q = l_syn[0];

  always_ff @(posedge link_clk)
  begin
    scl_d <= scl_q;
    sda_d <= sda_q;
  end

  assign start_c = scl_q & scl_d & sda_d & ~sda_q;
  assign stop_c = scl_q & scl_d & ~sda_d & sda_q;
  assign rise = scl_q & ~scl_d;
  assign fall = ~scl_q & scl_d;

  // Address byte in shift[7:1], direction in shift[0]
  assign match = shift[7:1] == own_addr // RULE7
               || (shift[7:1] == ARA_ADDR && shift[0] && lfault) // RULE8
               || (shift[7:1] == MASS_WR_ADDR && !shift[0] && lmass);

  always_ff @(posedge link_clk)
  begin
    if (lhold)
    begin
      state <= LS_IDLE; // RULE4
      bitc <= 4'h0;
      shift <= 8'h00;
      tx <= 8'h00;
      ptr <= 2'h0;
      first <= 1'b0;
      rw <= 1'b0;
      ara <= 1'b0;
      nack <= 1'b0;
      upstream_data_line_oe <= 1'b0;
      wr_tgl <= 1'b0;
      wr_addr <= 2'h0;
      wr_data <= 8'h00;
    end
    else if (start_c)
    begin
      state <= LS_ADDR; // RULE5
      bitc <= 4'h0;
      first <= 1'b1;
      upstream_data_line_oe <= 1'b0;
    end
    else if (stop_c)
    begin
      state <= LS_IDLE;
      upstream_data_line_oe <= 1'b0;
    end
    else
    begin
      case (state)
        LS_ADDR, LS_RX:
        begin
          if (rise)
          begin
            shift <= {shift[6:0], sda_q};
            bitc <= bitc + 4'h1;
          end
          else if (fall && bitc == BITS_PER_BYTE)
          begin
            if (state == LS_ADDR)
            begin
              state <= match ? LS_AACK : LS_SKIP;
              upstream_data_line_oe <= match;
              rw <= shift[0];
              ara <= shift[7:1] == ARA_ADDR; // RULE8
            end
            else
            begin
              state <= LS_RACK;
              upstream_data_line_oe <= 1'b1;
              first <= 1'b0;
              if (first)
                ptr <= shift[1:0];
              else
              begin
                wr_addr <= ptr;
                wr_data <= shift;
                wr_tgl <= ~wr_tgl;
                ptr <= ptr + 2'h1;
              end
            end
          end
        end
        LS_AACK, LS_TACK:
        begin
          if (rise)
            nack <= state == LS_TACK && sda_q;
          else if (fall)
          begin
            bitc <= 4'h0;
            if (!rw)
            begin
              state <= LS_RX;
              upstream_data_line_oe <= 1'b0;
            end
            else if (nack)
            begin
              state <= LS_SKIP;
              upstream_data_line_oe <= 1'b0;
            end
            else
            begin
              state <= LS_TX;
              tx <= ara ? {own_addr, 1'b0} : limg[ptr*8 +: 8]; // RULE8
              upstream_data_line_oe <= ara ? ~own_addr[6]
                                           : ~limg[ptr*8+7];
              ptr <= ara ? ptr : ptr + 2'h1;
            end
          end
        end
        LS_RACK:
        begin
          if (fall)
          begin
            state <= LS_RX;
            bitc <= 4'h0;
            upstream_data_line_oe <= 1'b0;
          end
        end
        LS_TX:
        begin
          if (rise)
          begin
            bitc <= bitc + 4'h1;
            // Lost alert arbitration to a lower address
            if (ara && !upstream_data_line_oe && !sda_q)
              state <= LS_SKIP; // RULE8
          end
          else if (fall)
          begin
            if (bitc == BITS_PER_BYTE)
            begin
              state <= LS_TACK;
              upstream_data_line_oe <= 1'b0;
            end
            else
            begin
              tx <= {tx[6:0], 1'b0};
              upstream_data_line_oe <= ~tx[6];
            end
          end
        end
        LS_SKIP:
          upstream_data_line_oe <= 1'b0;
        default:
          state <= LS_IDLE;
      endcase
    end
  end

  assign upstream_data_line_out = 1'b0;

  // Checks, system domain
  AST_FAULT_IN: assert property (@(posedge sys_clk) disable iff (reset) // RULE1
    (!s_syn[9] || !s_syn[8]) |=> fault_line_oe)
    else $error("fault input low but fault line released");
  AST_TMO_FAULT: assert property (@(posedge sys_clk) disable iff (reset) // RULE2
    $rose(stuck_disconnect) |-> tmo_latched ##1 fault_line_oe[*2])
    else $error("timeout did not latch and assert fault");
  AST_REFUSE: assert property (@(posedge sys_clk) disable iff (reg_rst) // RULE3
    (sw_write && wr_data[SW_CH1] && !cfg[CF_CONNREQ] && !bus_hi[0]
     && !channel_join[0] && !tmo_hit)
    |=> !channel_join[0] && !status[ST_FAIL_N] ##1 fault_line_oe)
    else $error("low channel joined or refusal not reported");
  AST_DISABLE: assert property (@(posedge sys_clk) disable iff (reset) // RULE4
    !s_syn[1] |=> accel == ACCEL_RESET && channel_join == 2'h0
                  && cfg == CONNCFG_RESET && !tmo_latched)
    else $error("registers not at default while disabled");
  AST_READY: assert property (@(posedge sys_clk) disable iff (reset) // RULE6
    $changed(channel_join == 2'h0) |=> ready_line_oe == (channel_join == 2'h0))
    else $error("ready line does not follow joined state");
  AST_CLEAR: assert property (@(posedge sys_clk) disable iff (reg_rst) // RULE14
    (stat_clear && !tmo_hit && !sw_write) |=> !tmo_latched && !fail_seen
      && $stable(channel_join) && $stable(accel) && $stable(cfg))
    else $error("status write did not clear only the fault latches");
  AST_ACCEL: assert property (@(posedge sys_clk) disable iff (reg_rst) // RULE15
    (wr_pulse && wr_addr == REG_ACCEL) |=> upstream_accel_en == $past(wr_data[7])
      && downstream_accel_en == $past(wr_data[6]) && accel[5:0] == 6'h00)
    else $error("accelerator enables not written");
  AST_TMO_OFF: assert property (@(posedge sys_clk) disable iff (reg_rst) // RULE18
    (cfg[1:0] == TMO_OFF)[*2] |-> !stuck_disconnect)
    else $error("timeout active while disabled");
  AST_TMO_RT: assert property (@(posedge sys_clk) disable iff (reg_rst) // RULE13
    stuck_disconnect |-> $past(up_stuck) && channel_join == 2'h0)
    else $error("real-time timeout without stuck bus");

  // Checks, link domain
  AST_ADDR_ACK: assert property (@(posedge link_clk) disable iff (lhold) // RULE7
    (state == LS_ADDR && fall && bitc == BITS_PER_BYTE && match)
    |=> state == LS_AACK && upstream_data_line_oe)
    else $error("matching address not acknowledged");
  AST_IGNORE: assert property (@(posedge link_clk) // RULE4
    lhold |=> state == LS_IDLE && !upstream_data_line_oe)
    else $error("bus traffic answered while disabled");

  COV_REFUSE: cover property (@(posedge sys_clk) sw_write && |refused);
  COV_TIMEOUT: cover property (@(posedge sys_clk) $rose(stuck_disconnect));
  COV_CLEAR: cover property (@(posedge sys_clk) stat_clear && tmo_latched);
  COV_ARA: cover property (@(posedge link_clk) state == LS_TX && ara);

endmodule : tcmux_ctrl

// ---- logic/tcmux_pkg.sv ----
/*
  Shared constants of the two-channel bus multiplexer control block:
  register map, field positions, reset values, addresses, timeout
  figures and the state and mode types.
  Assumes a 50 MHz system clock and a separate link sampling clock.
  // Contract
  // (RULE1) Fault input low pulls fault output low
  // (RULE2) Stuck-low timeout pulls fault output low
  // (RULE3) Refused low-bus connection pulls fault low
  // (RULE4) Enable low: ignore bus, reset registers
  // (RULE5) Enable high: accept reads and writes
  // (RULE6) Ready pulled low while nothing joined
  // (RULE7) Three tristate pins give 27 addresses
  // (RULE8) Answer the alert response address
  // (RULE9) Status bit 7 shows any channel joined
  // (RULE10) Status bits 6,5 mirror fault inputs
  // (RULE11) Status bit 2 low after refused connection
  // (RULE12) Status bit 1 latches timeout until cleared
  // (RULE13) Status bit 0 shows timeout in progress
  // (RULE14) Status write clears fault latches only
  // (RULE15) Control bit 7 enables upstream accelerators
  // (RULE16) Control bit 6 downstream; rest read-only
  // (RULE17) Connect only high buses unless overridden
  // (RULE18) Timeout code: off, 30, 15, 7.5 ms
  // (RULE19) Fault holds until status write, cause gone
*/
package tcmux_pkg;

  // Register indices
  localparam logic [1:0] REG_STATUS = 2'h0;
  localparam logic [1:0] REG_ACCEL = 2'h1;
  localparam logic [1:0] REG_CONNCFG = 2'h2;
  localparam logic [1:0] REG_SWITCH = 2'h3;

  // Field positions
  localparam int ST_JOINED = 7;
  localparam int ST_FAULT1 = 6;
  localparam int ST_FAULT2 = 5;
  localparam int ST_FAIL_N = 2;
  localparam int ST_TMO_LATCH = 1;
  localparam int ST_TMO_NOW = 0;
  localparam int AC_UP = 7;
  localparam int AC_DOWN = 6;
  localparam int CF_CONNREQ = 5;
  localparam int CF_MASSWR = 2;
  localparam int SW_CH1 = 7;
  localparam int SW_BUS1 = 3;

  // Reset values and writable masks
  localparam logic [7:0] ACCEL_RESET = 8'h00;
  localparam logic [7:0] ACCEL_WMASK = 8'hC0;
  localparam logic [7:0] CONNCFG_RESET = 8'h04;
  localparam logic [7:0] CONNCFG_WMASK = 8'h27;

  // Bus addresses; base is arbitrary, alert and mass-write are fixed
  localparam logic [6:0] DEV_ADDR_BASE = 7'h40;
  localparam logic [6:0] ARA_ADDR = 7'h0C;
  localparam logic [6:0] MASS_WR_ADDR = 7'h5E;

  // Sensed level of a three-state address pin
  localparam logic [1:0] TRI_LOW = 2'h0;
  localparam logic [1:0] TRI_FLOAT = 2'h1;
  localparam logic [1:0] TRI_HIGH = 2'h2;

  // Timeout figures
  localparam int SYS_CLK_MHZ = 50;
  localparam int TMO_LONG_US = 30000;
  localparam int TMO_MID_US = 15000;
  localparam int TMO_SHORT_US = 7500;
  localparam int TMO_LONG_CYC = TMO_LONG_US * SYS_CLK_MHZ;
  localparam int TMO_MID_CYC = TMO_MID_US * SYS_CLK_MHZ;
  localparam int TMO_SHORT_CYC = TMO_SHORT_US * SYS_CLK_MHZ;
  localparam int TMO_CNT_W = 21;

  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef enum logic [1:0] {
    TMO_OFF = 2'b00,
    TMO_30MS = 2'b01,
    TMO_15MS = 2'b10,
    TMO_7P5MS = 2'b11
  } tcmux_tmo_t;

  typedef enum logic [2:0] {
    LS_IDLE = 3'b000,
    LS_ADDR = 3'b001,
    LS_AACK = 3'b011,
    LS_RX = 3'b010,
    LS_RACK = 3'b110,
    LS_TX = 3'b111,
    LS_TACK = 3'b101,
    LS_SKIP = 3'b100
  } tcmux_state_t;

  function automatic logic [6:0] tcmux_digit(input logic [1:0] lvl);
    tcmux_digit = (lvl == TRI_HIGH) ? 7'h02 :
                  (lvl == TRI_FLOAT) ? 7'h01 : 7'h00;
  endfunction : tcmux_digit

  // Base-3 address from the three pins, high pin most significant
  function automatic logic [6:0] tcmux_addr(input logic [1:0] hi,
                                            input logic [1:0] mid,
                                            input logic [1:0] lo);
    tcmux_addr = DEV_ADDR_BASE + 7'h09 * tcmux_digit(hi)
               + 7'h03 * tcmux_digit(mid) + tcmux_digit(lo);
  endfunction : tcmux_addr

endpackage : tcmux_pkg

// ---- logic/tcmux_sync.sv ----
/*
  Two-flop level synchroniser, one per bit.
  Assumes each bit is a level or a toggle that changes slowly
  compared with the receiving clock.
*/
`timescale 1ns/1ps
module tcmux_sync #(
  parameter int WIDTH = 1
) (
  // Receiving clock
  input wire logic clk,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk)
  begin
    meta <= async_in;
    sync_out <= meta;
  end

endmodule : tcmux_sync

// ---- test/tcmux_master.sv ----
/*
  Upstream two-wire master model: START, STOP and byte transfers
  on open-drain lines, one quarter bit per step.
  Assumes the bench resolves the data wire from both pull-downs.
*/
`timescale 1ns/1ps
module tcmux_master #(
  parameter int Q = 240
) (
  // Open-drain lines, 1 = released
  output logic scl,
  output logic sda,
  // Resolved data wire
  input wire logic sda_wire
);
  initial
  begin
    scl = 1'b1;
    sda = 1'b1;
  end

  // Also a repeated START; slave gets a quarter to let go first
  task automatic start();
    sda = 1'b1;
    #Q scl = 1'b1;
    #Q sda = 1'b0;
    #Q scl = 1'b0;
    #Q;
  endtask : start

  task automatic stop();
    sda = 1'b0;
    #Q scl = 1'b1;
    #Q sda = 1'b1;
    #Q;
  endtask : stop

  // Data moves only while the clock is low
  task automatic xbit(input logic b, output logic r);
    sda = b;
    #Q scl = 1'b1;
    #Q r = sda_wire;
    #Q scl = 1'b0;
    #Q;
  endtask : xbit

  task automatic xbyte(input logic [7:0] d, input logic a,
                       output logic [7:0] q, output logic r);
    for (int i = 7; i >= 0; i--)
    begin
      xbit(d[i], q[i]);
    end
    xbit(a, r);
  endtask : xbyte

  task automatic hold(input logic b);
    scl = b;
  endtask : hold
endmodule : tcmux_master

// ---- test/tb.sv ----
/*
  Self-checking bench of the multiplexer control block.
  Assumes the master model on the upstream lines; short timeouts.
*/
`timescale 1ns/1ps
module tb;
  typedef struct packed {
    logic [7:0] w;
    logic [7:0] r;
    logic up;
    logic dn;
  } tcmux_row_t;
  tcmux_row_t rows [4] = '{'{8'hFF, 8'hC0, 1'b1, 1'b1},
    '{8'h80, 8'h80, 1'b1, 1'b0}, '{8'h40, 8'h40, 1'b0, 1'b1},
    '{8'h3F, 8'h00, 1'b0, 1'b0}};
  int lim [4] = '{0, 4000, 2000, 1000};
  logic sys_clk = 1'b0;
  logic link_clk = 1'b0;
  logic reset = 1'b1;
  logic f1 = 1'b1;
  logic f2 = 1'b1;
  logic d1 = 1'b1, c1 = 1'b1, d2 = 1'b1, c2 = 1'b1;
  logic en = 1'b1;
  logic [1:0] a_lo = 2'h1;
  logic [1:0] a_mid = 2'h1;
  logic [1:0] a_hi = 2'h1;
  logic scl, sda_rel, sda_out, sda_oe, flt_out, flt_oe, rdy_out, rdy_oe;
  logic up_acc, dn_acc, stuck, ak;
  logic [1:0] join_q;
  logic [7:0] q;
  logic [6:0] adr = 7'h4D;
  wire sda_wire = sda_rel & ~sda_oe;
  int error_cnt = 0;
  int total_checks = 0;

  always #10 sys_clk = ~sys_clk;
  // Odd offset keeps the two clocks out of step
  initial
  begin
    #13;
    forever #40 link_clk = ~link_clk;
  end

  tcmux_master #(.Q(240)) m (.scl(scl), .sda(sda_rel),
    .sda_wire(sda_wire));

  tcmux_ctrl #(.TMO_LONG(4000), .TMO_MID(2000), .TMO_SHORT(1000)) dut (
    .sys_clk(sys_clk), .reset(reset), .link_clk(link_clk),
    .upstream_clock_line(scl), .upstream_data_line_in(sda_wire),
    .upstream_data_line_out(sda_out), .upstream_data_line_oe(sda_oe),
    .downstream_fault_in_first(f1), .downstream_fault_in_second(f2),
    .downstream_data_first(d1), .downstream_clock_first(c1),
    .downstream_data_second(d2), .downstream_clock_second(c2),
    .enable_in(en), .tristate_address_pin_low(a_lo),
    .tristate_address_pin_mid(a_mid), .tristate_address_pin_high(a_hi),
    .fault_line_out(flt_out), .fault_line_oe(flt_oe),
    .ready_line_out(rdy_out), .ready_line_oe(rdy_oe),
    .channel_join(join_q), .upstream_accel_en(up_acc),
    .downstream_accel_en(dn_acc), .stuck_disconnect(stuck));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cyc

  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    logic r;
    logic [7:0] x;
    m.start();
    m.xbyte({adr, 1'b0}, 1'b1, x, r);
    m.xbyte(p, 1'b1, x, r);
    m.xbyte(d, 1'b1, x, r);
    m.stop();
    chk(8'(r), 8'h00);
    cyc(4);
  endtask : wr

  task automatic rd(input logic [7:0] p, output logic [7:0] x);
    logic r;
    m.start();
    m.xbyte({adr, 1'b0}, 1'b1, x, r);
    m.xbyte(p, 1'b1, x, r);
    m.start();
    m.xbyte({adr, 1'b1}, 1'b1, x, r);
    m.xbyte(8'hFF, 1'b1, x, r);
    m.stop();
  endtask : rd

  task automatic probe(input logic [6:0] a, output logic ack);
    logic [7:0] x;
    logic r;
    m.start();
    m.xbyte({a, 1'b0}, 1'b1, x, r);
    m.stop();
    ack = ~r;
  endtask : probe

  task automatic close_out();
    $display("Checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : close_out

  initial
  begin
    #2_000_000;
    error_cnt++;
    close_out();
  end

  initial
  begin
    cyc(5);
    chk(8'(rdy_oe), 8'h01);
    chk({7'h00, rdy_out}, 8'h00);
    chk({6'h00, join_q}, 8'h00);
    reset = 1'b0;
    cyc(50);
    rd(8'h00, q);
    chk(q, 8'h64);
    rd(8'h01, q);
    chk(q, 8'h00);
    foreach (rows[i])
    begin
      wr(8'h01, rows[i].w);
      chk({6'h00, up_acc, dn_acc}, {6'h00, rows[i].up, rows[i].dn});
      rd(8'h01, q);
      chk(q, rows[i].r);
    end
    for (int i = 0; i < 4; i++)
    begin
      f1 = i[0];
      f2 = i[1];
      cyc(8);
      chk(8'(flt_oe), {7'h00, ~(f1 & f2)});
      rd(8'h00, q);
      chk(q, {1'b0, f1, f2, 5'h04});
    end
    f1 = 1'b0;
    cyc(8);
    m.start();
    m.xbyte({7'h0C, 1'b1}, 1'b1, q, ak);
    chk(8'(ak), 8'h00);
    m.xbyte(8'hFF, 1'b1, q, ak);
    m.stop();
    chk(q, {adr, 1'b0});
    chk({6'h00, flt_out, sda_out}, 8'h00);
    f1 = 1'b1;
    wr(8'h03, 8'h80);
    chk({6'h00, join_q}, 8'h01);
    chk(8'(rdy_oe), 8'h00);
    rd(8'h00, q);
    chk(q, 8'hE4);
    wr(8'h03, 8'h00);
    chk(8'(rdy_oe), 8'h01);
    c1 = 1'b0;
    d2 = 1'b0;
    wr(8'h03, 8'hC0);
    chk({6'h00, join_q}, 8'h00);
    chk(8'(flt_oe), 8'h01);
    rd(8'h00, q);
    chk(q, 8'h60);
    wr(8'h00, 8'hFF);
    chk(8'(flt_oe), 8'h00);
    d1 = 1'b0;
    c2 = 1'b0;
    wr(8'h02, 8'h24);
    wr(8'h03, 8'hC0);
    chk({6'h00, join_q}, 8'h03);
    wr(8'h03, 8'h00);
    {d1, c1, d2, c2} = 4'hF;
    // Shortest limit last: transfers must not trip it
    for (int md = 1; md < 4; md++)
    begin
      wr(8'h02, 8'h04 | 8'(md));
      m.hold(1'b0);
      cyc(lim[md] - 40);
      chk(8'(stuck), 8'h00);
      cyc(80);
      chk(8'(stuck), 8'h01);
      chk(8'(flt_oe), 8'h01);
      m.hold(1'b1);
      cyc(20);
      chk(8'(stuck), 8'h00);
      chk(8'(flt_oe), 8'h01);
      rd(8'h00, q);
      chk(q, 8'h66);
      wr(8'h00, 8'hFF);
      chk(8'(flt_oe), 8'h00);
    end
    wr(8'h02, 8'h04);
    m.hold(1'b0);
    cyc(1200);
    chk(8'(stuck), 8'h00);
    m.hold(1'b1);
    wr(8'h01, 8'hC0);
    en = 1'b0;
    f1 = 1'b0;
    cyc(8);
    chk(8'(up_acc), 8'h00);
    chk(8'(flt_oe), 8'h01);
    f1 = 1'b1;
    probe(adr, ak);
    chk(8'(ak), 8'h00);
    en = 1'b1;
    cyc(50);
    rd(8'h01, q);
    chk(q, 8'h00);
    for (int k = 0; k < 27; k++)
    begin
      a_hi = 2'(k / 9);
      a_mid = 2'((k / 3) % 3);
      a_lo = 2'(k % 3);
      cyc(50);
      probe(7'h40 + 7'(k), ak);
      chk(8'(ak), 8'h01);
    end
    probe(7'h5B, ak);
    chk(8'(ak), 8'h00);
    close_out();
  end
endmodule : tb
